/* File: bench/cbrf_far_end.sv */
`default_nettype none
module cbrf_far_end
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic rd_req,
    input wire logic [15:0] rd_addr,
    input wire logic rx_pop,
    output logic [7:0] mem_rdata,
    output logic [7:0] rx_fifo_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Low address byte only; the bench checks the full address itself
    logic [7:0] mem [256] = '{default: 8'h00};
    logic [7:0] rx_cnt = 8'h00;
    logic [7:0] noise = 8'h00;
    always @(posedge core_clk)
    begin
        noise <= noise + 8'h3B;
        if (mem_we)
            mem[mem_addr[7:0]] <= mem_wdata;
        if (srst)
            rx_cnt <= 8'h00;
        else if (rx_pop)
            rx_cnt <= rx_cnt + 8'h01;
    end
    // Churn while idle so a stale byte cannot pass as a read
    assign mem_rdata = rd_req ? mem[rd_addr[7:0]] : noise;
    assign rx_fifo_data = 8'h5A + rx_cnt;
endmodule
`default_nettype wire

/* File: bench/cbrf_tb_top.sv */
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            $display("MISMATCH %s exp %h got %h", nm, e, g); \
            n_errors++; \
        end \
    end
module cpu_banked_register_file_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, srst = 1, instr_valid = 0, mem_rd = 0, mem_wr = 0;
    logic [2:0] instr_op = 0;
    logic [1:0] instr_src = 0, idx_sel = 0, idx_mode = 0;
    logic [4:0] src_loc = 0, dst_loc = 0;
    logic [7:0] imm_field = 0, mem_rdata, rx_fifo_data;
    logic exch = 0, exch_main_a = 0, exch_main_b = 0;
    logic exch_int_set = 0, exch_int_val = 0;
    logic busy, imm_fault, mem_we, mem_re, tx_push, rx_pop;
    logic alt_a_sel, alt_b_sel, int_enable;
    logic [7:0] src_bus, mem_wdata, tx_fifo_data;
    logic [15:0] mem_addr, rd_addr = 0;
    logic [7:0] rf [64] = '{default: 8'h00};
    logic [7:0] mexp [256] = '{default: 8'h00};
    logic [7:0] pops = 0;
    bit alt_a = 1, alt_b = 1, ie = 0;
    int n_errors = 0, samples_checked = 0, cyc = 0;

    cbrf_top i_dut (.core_clk, .srst, .instr_valid, .instr_op, .instr_src,
        .src_loc, .dst_loc, .imm_field, .mem_rd, .mem_wr, .idx_sel,
        .idx_mode, .mem_rdata, .exch, .exch_main_a, .exch_main_b,
        .exch_int_set, .exch_int_val, .rx_fifo_data, .busy, .imm_fault,
        .src_bus, .mem_wdata, .mem_we, .mem_re, .mem_addr, .tx_push,
        .tx_fifo_data, .rx_pop, .alt_a_sel, .alt_b_sel, .int_enable);
    cbrf_far_end i_far (.core_clk, .srst, .mem_we, .mem_addr, .mem_wdata,
        .rd_req(mem_rd), .rd_addr, .rx_pop, .mem_rdata, .rx_fifo_data);

    always #5 core_clk = ~core_clk;

    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Whole run is well under a thousand cycles
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            stop_test();
        end
    end

    function automatic int phys(logic [4:0] l);
        if (l <= 5'h03 && alt_a)
            return int'(l) + 32;
        if (l >= 5'h04 && l <= 5'h0B && alt_b)
            return int'(l) + 32;
        return int'(l);
    endfunction

    function automatic logic [7:0] alu(logic [2:0] op, logic [7:0] a,
        logic [7:0] x);
        case (op)
            3'h1: return a + x;
            3'h2: return x - a;
            3'h3: return a & x;
            3'h4: return a | x;
            3'h5: return a ^ x;
            default: return x;
        endcase
    endfunction

    // Transceiver status bytes of the alternate bank are avoided
    function automatic logic [4:0] pick();
        logic [4:0] l;
        l = 5'($urandom_range(27));
        if (alt_b && l >= 5'h05 && l <= 5'h07)
            l = l + 5'h10;
        return l;
    endfunction

    task automatic drive(logic [2:0] op, logic [1:0] sk, logic [4:0] s,
        logic [4:0] d, logic [7:0] im, bit rd, bit wr, logic [1:0] m);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_src <= sk;
        src_loc <= s;
        dst_loc <= d;
        imm_field <= im;
        mem_rd <= rd;
        mem_wr <= wr;
        idx_mode <= m;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
        #1;
    endtask

    task automatic run_op(logic [2:0] op, logic [1:0] sk, logic [4:0] s,
        logic [4:0] d, logic [7:0] im);
        bit fs;
        bit fd;
        bit flt;
        logic [7:0] x;
        logic [7:0] r;
        fs = alt_b && s == 5'h04 && sk == 2'h0;
        fd = alt_b && d == 5'h04;
        flt = sk == 2'h2 && d >= 5'h10;
        x = sk == 2'h2 ? im : fs ? 8'h5A + pops : rf[phys(s)];
        r = alu(op, rf[phys(5'h08)], x);
        drive(op, sk, s, d, im, 1'b0, 1'b0, 2'h0);
        if (sk == 2'h0)
            `CHK("src_bus", x, src_bus)
        `CHK("rx_pop", fs, rx_pop)
        `CHK("tx_push", fd, tx_push)
        if (fd)
            `CHK("tx_fifo_data", r, tx_fifo_data)
        `CHK("imm_fault", flt, imm_fault)
        if (fs)
            pops++;
        if (!flt && !fd)
            rf[phys(d)] = r;
        @(posedge core_clk);
    endtask

    task automatic mem_op(bit wr, logic [1:0] sel, logic [1:0] m,
        logic [4:0] loc);
        int lo;
        logic [15:0] ix;
        logic [15:0] a;
        lo = 12 + 2 * int'(sel);
        ix = {rf[lo + 1], rf[lo]};
        a = m == 2'h3 ? ix + 16'h1 : ix;
        ix = m == 2'h2 ? ix - 16'h1 : m == 2'h0 ? ix : ix + 16'h1;
        {rf[lo + 1], rf[lo]} = ix;
        rd_addr <= a;
        idx_sel <= sel;
        drive(3'h0, wr ? 2'h0 : 2'h1, loc, loc, 8'h00, !wr, wr, m);
        `CHK("mem_addr", a, mem_addr)
        `CHK("mem_we", wr, mem_we)
        `CHK("mem_re", !wr, mem_re)
        if (wr)
        begin
            `CHK("mem_wdata", rf[phys(loc)], mem_wdata)
            mexp[a[7:0]] = rf[phys(loc)];
        end
        else
            rf[phys(loc)] = mexp[a[7:0]];
        @(posedge core_clk);
    endtask

    task automatic exch_do(bit ma, bit mb, bit is, bit iv);
        instr_valid <= 1'b1;
        exch <= 1'b1;
        exch_main_a <= ma;
        exch_main_b <= mb;
        exch_int_set <= is;
        exch_int_val <= iv;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        exch <= 1'b0;
        #1;
        `CHK("busy", 1'b1, busy)
        @(posedge core_clk);
        #1;
        if (is)
            ie = iv;
        `CHK("busy", 1'b0, busy)
        `CHK("alt_a_sel", !ma, alt_a_sel)
        `CHK("alt_b_sel", !mb, alt_b_sel)
        `CHK("int_enable", ie, int_enable)
        alt_a = !ma;
        alt_b = !mb;
        @(posedge core_clk);
    endtask

    initial
    begin
        void'($urandom(68));
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        #1;
        `CHK("alt_a_sel", 1'b1, alt_a_sel)
        `CHK("alt_b_sel", 1'b1, alt_b_sel)
        @(posedge core_clk);
        run_op(3'h0, 2'h2, 5'h00, 5'h0F, 8'hA5);
        run_op(3'h0, 2'h2, 5'h00, 5'h10, 8'h3C);
        run_op(3'h1, 2'h0, 5'h0F, 5'h0F, 8'h00);
        exch_do(1'b0, 1'b0, 1'b0, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            exch_do(k[1], k[0], 1'b1, k[0]);
            run_op(3'h1, 2'h0, 5'h05, 5'h14, 8'h00);
            for (int i = 0; i < 40; i++)
                run_op(3'($urandom_range(5)), 2'($urandom_range(1) * 2),
                    pick(), pick(), 8'($urandom));
        end
        for (int s = 0; s < 4; s++)
            for (int m = 0; m < 4; m++)
            begin
                mem_op(1'b1, 2'(s), 2'(m), 5'(20 + m));
                mem_op(1'b0, 2'(s), 2'h0, 5'(24 + m));
            end
        for (int s = 12; s < 28; s++)
            run_op(3'h0, 2'h0, 5'(s), 5'h1B, 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire

/* File: hw/cbrf_mem_if.sv */
`default_nettype none
interface cbrf_mem_if;
    logic [5:0] wr_idx;
    logic [5:0] rd_idx;
    logic [5:0] acc_idx;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] acc_data;
    modport owner (output wr_idx, rd_idx, acc_idx, wr_en, wr_data,
        input rd_data, acc_data);
    modport store (input wr_idx, rd_idx, acc_idx, wr_en, wr_data,
        output rd_data, acc_data);
endinterface
`default_nettype wire

/* File: hw/cbrf_pkg.sv */
`default_nettype none
package cbrf_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int INDEX_W = 16;
    localparam int IMM_LIMIT = 16;
    localparam int GRP_A_LAST = 3;
    localparam int GRP_B_LAST = 11;
    localparam int ALT_B_GP_FIRST = 8;
    localparam logic [4:0] ACC_LOC = 5'h08;
    localparam logic [4:0] FIFO_PORT_LOC = 5'h04;
    localparam logic [4:0] IDX_FIRST = 5'h0C;
    localparam logic [4:0] IDX_LAST = 5'h13;
    localparam logic [4:0] ALWAYS_FIRST = 5'h14;
    localparam logic [4:0] ALWAYS_LAST = 5'h1B;
    localparam logic BANK_RST_ALT = 1'b1;
    localparam int EXCH_STATES = 2;
    localparam int IDX_MODE_W = 2;
    localparam logic [1:0] IDX_HOLD = 2'h0;
    localparam logic [1:0] IDX_POST_INC = 2'h1;
    localparam logic [1:0] IDX_POST_DEC = 2'h2;
    localparam logic [1:0] IDX_PRE_INC = 2'h3;
    typedef enum logic [2:0]
    {
        CBRF_OP_PASS,
        CBRF_OP_ADD,
        CBRF_OP_SUB,
        CBRF_OP_AND,
        CBRF_OP_OR,
        CBRF_OP_XOR
    } cbrf_op_e;
    typedef enum logic [1:0]
    {
        CBRF_SRC_REG,
        CBRF_SRC_MEM,
        CBRF_SRC_IMM
    } cbrf_src_e;
    typedef enum logic
    {
        CBRF_ST_IDLE,
        CBRF_ST_EXCH
    } cbrf_state_e;
endpackage
`default_nettype wire

/* File: hw/cbrf_store.sv */
`default_nettype none
// Physical byte store; combinational read gives old value in write cycle
module cbrf_store #(
    parameter int DEPTH = 32
)
(
    input wire logic core_clk,
    input wire logic srst,
    cbrf_mem_if.store mp
);
    logic [7:0] mem [DEPTH];
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= 8'h00;
        end
        else if (mp.wr_en)
            mem[mp.wr_idx] <= mp.wr_data;
    end
    assign mp.rd_data = mem[mp.rd_idx];
    assign mp.acc_data = mem[mp.acc_idx];
endmodule
`default_nettype wire

/* File: hw/cbrf_top.sv */
`default_nettype none
// Functional notes
// - Separate read and write paths; one register may be source and target.
// - Source register drives source bus; target captures destination bus.
// - All data flows through the select unit: register, memory or immediate.
// - Memory write sends source value through unit onto memory pins.
// - Memory read places the incoming byte into the target register.
// - Memory address comes from one of four 16-bit index registers.
// - FIFO port location: write pushes transmit FIFO, read pops receive FIFO.
// - Immediate load routes an instruction field into the target register.
// - Host-side control register is absent from the CPU address space.
// - Register operands are 5-bit fields selecting 32 locations.
// - Locations 0-11 form banked groups A and B, one bank visible each.
// - Exchange picks main or alternate independently for A and B.
// - Immediate instructions address only locations 0 to 15.
// - Main B: eight general at 4-11; alternate B: four at 8-11.
// - Locations 20-27 are general registers visible in every bank.
// - Two-operand ops use location 8 of active B bank as accumulator.
// - After reset both groups select the alternate bank.
// - Exchange takes two states and may change interrupt enable.
// - Register accesses insert no memory wait states.
// - Forty-four distinct bytes reachable through banked space.
module cbrf_top
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic instr_valid,
    input wire logic [2:0] instr_op,
    input wire logic [1:0] instr_src,
    input wire logic [4:0] src_loc,
    input wire logic [4:0] dst_loc,
    input wire logic [7:0] imm_field,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [1:0] idx_sel,
    input wire logic [1:0] idx_mode,
    input wire logic [7:0] mem_rdata,
    input wire logic exch,
    input wire logic exch_main_a,
    input wire logic exch_main_b,
    input wire logic exch_int_set,
    input wire logic exch_int_val,
    input wire logic [7:0] rx_fifo_data,
    output logic busy,
    output logic imm_fault,
    output logic [7:0] src_bus,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic mem_re,
    output logic [15:0] mem_addr,
    output logic tx_push,
    output logic [7:0] tx_fifo_data,
    output logic rx_pop,
    output logic alt_a_sel,
    output logic alt_b_sel,
    output logic int_enable
);
    cbrf_mem_if mif();
    cbrf_store #(.DEPTH(64)) u_store
    (
        .core_clk(core_clk),
        .srst(srst),
        .mp(mif.store)
    );

    cbrf_pkg::cbrf_state_e state;
    cbrf_pkg::cbrf_state_e next_state;
    logic bank_a;
    logic bank_b;
    logic pend_a;
    logic pend_b;
    logic [15:0] idx_reg [4];

    // Physical index: bit 5 picks the alternate copy of banked bytes
    function automatic logic [5:0] phys(input logic [4:0] loc,
        input logic ba, input logic bb);
        logic alt;
        alt = 1'b0;
        if (loc <= 5'(cbrf_pkg::GRP_A_LAST))
            alt = ba;
        else if (loc <= 5'(cbrf_pkg::GRP_B_LAST))
            alt = bb;
        return {alt, loc};
    endfunction

    wire idle = state == cbrf_pkg::CBRF_ST_IDLE;
    // Exchange touches no register, memory or FIFO
    wire exch_go = instr_valid && exch && idle;
    wire issue = instr_valid && !exch && idle;
    wire is_imm = instr_src == cbrf_pkg::CBRF_SRC_IMM;
    wire imm_bad = is_imm && dst_loc >= 5'(cbrf_pkg::IMM_LIMIT);
    wire is_idx_src = src_loc >= cbrf_pkg::IDX_FIRST
        && src_loc <= cbrf_pkg::IDX_LAST;
    wire is_idx_dst = dst_loc >= cbrf_pkg::IDX_FIRST
        && dst_loc <= cbrf_pkg::IDX_LAST;
    wire src_fifo = bank_b && src_loc == cbrf_pkg::FIFO_PORT_LOC;
    wire dst_fifo = bank_b && dst_loc == cbrf_pkg::FIFO_PORT_LOC;
    wire [2:0] src_ib = 3'(src_loc - cbrf_pkg::IDX_FIRST);
    wire [2:0] dst_ib = 3'(dst_loc - cbrf_pkg::IDX_FIRST);
    wire [7:0] idx_rbyte = src_ib[0] ? idx_reg[src_ib[2:1]][15:8]
        : idx_reg[src_ib[2:1]][7:0];
    // Source bus straight from the read port, before any write lands
    wire [7:0] src_val = src_fifo ? rx_fifo_data
        : is_idx_src ? idx_rbyte : mif.rd_data;
    wire [7:0] mux_in = instr_src == cbrf_pkg::CBRF_SRC_MEM ? mem_rdata
        : is_imm ? imm_field : src_val;
    wire [7:0] acc = mif.acc_data;
    logic [7:0] dst_bus;
    always_comb
    begin
        case (instr_op)
            cbrf_pkg::CBRF_OP_ADD: dst_bus = 8'(acc + mux_in);
            cbrf_pkg::CBRF_OP_SUB: dst_bus = 8'(mux_in - acc);
            cbrf_pkg::CBRF_OP_AND: dst_bus = acc & mux_in;
            cbrf_pkg::CBRF_OP_OR: dst_bus = acc | mux_in;
            cbrf_pkg::CBRF_OP_XOR: dst_bus = acc ^ mux_in;
            default: dst_bus = mux_in;
        endcase
    end
    wire do_reg_wr = issue && !mem_wr && !imm_bad && !dst_fifo
        && !is_idx_dst;
    wire do_mem_wr = issue && mem_wr;
    wire do_mem_rd = issue && mem_rd && !mem_wr;

    assign mif.rd_idx = phys(src_loc, bank_a, bank_b);
    assign mif.acc_idx = phys(cbrf_pkg::ACC_LOC, bank_a, bank_b);
    assign mif.wr_idx = phys(dst_loc, bank_a, bank_b);
    assign mif.wr_en = do_reg_wr;
    assign mif.wr_data = dst_bus;

    always_comb
    begin
        next_state = state;
        case (state)
            cbrf_pkg::CBRF_ST_IDLE:
                if (exch_go)
                    next_state = cbrf_pkg::CBRF_ST_EXCH;
            cbrf_pkg::CBRF_ST_EXCH:
                next_state = cbrf_pkg::CBRF_ST_IDLE;
            default: next_state = cbrf_pkg::CBRF_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state <= cbrf_pkg::CBRF_ST_IDLE;
            bank_a <= cbrf_pkg::BANK_RST_ALT;
            bank_b <= cbrf_pkg::BANK_RST_ALT;
            pend_a <= cbrf_pkg::BANK_RST_ALT;
            pend_b <= cbrf_pkg::BANK_RST_ALT;
            int_enable <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (exch_go)
            begin
                pend_a <= !exch_main_a;
                pend_b <= !exch_main_b;
                if (exch_int_set)
                    int_enable <= exch_int_val;
            end
            if (state == cbrf_pkg::CBRF_ST_EXCH)
            begin
                bank_a <= pend_a;
                bank_b <= pend_b;
            end
        end
    end

    // Index registers: byte writes, and address stepping
    genvar g;
    for (g = 0; g < 4; g++)
    begin : g_idx
        wire sel = do_mem_wr || do_mem_rd ? idx_sel == 2'(g) : 1'b0;
        wire wr_lo = issue && !mem_wr && !imm_bad && is_idx_dst
            && dst_ib == 3'(2 * g);
        wire wr_hi = issue && !mem_wr && !imm_bad && is_idx_dst
            && dst_ib == 3'(2 * g + 1);
        always_ff @(posedge core_clk)
        begin
            if (srst)
                idx_reg[g] <= 16'h0000;
            else if (wr_lo)
                idx_reg[g][7:0] <= dst_bus;
            else if (wr_hi)
                idx_reg[g][15:8] <= dst_bus;
            else if (sel && idx_mode != cbrf_pkg::IDX_HOLD)
                idx_reg[g] <= idx_mode == cbrf_pkg::IDX_POST_DEC
                    ? 16'(idx_reg[g] - 16'h0001)
                    : 16'(idx_reg[g] + 16'h0001);
        end
    end

    wire [15:0] cur_idx = idx_reg[idx_sel];
    wire [15:0] addr_val = idx_mode == cbrf_pkg::IDX_PRE_INC
        ? 16'(cur_idx + 16'h0001) : cur_idx;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            busy <= 1'b0;
            imm_fault <= 1'b0;
            src_bus <= 8'h00;
            mem_wdata <= 8'h00;
            mem_we <= 1'b0;
            mem_re <= 1'b0;
            mem_addr <= 16'h0000;
            tx_push <= 1'b0;
            tx_fifo_data <= 8'h00;
            rx_pop <= 1'b0;
            alt_a_sel <= cbrf_pkg::BANK_RST_ALT;
            alt_b_sel <= cbrf_pkg::BANK_RST_ALT;
        end
        else
        begin
            busy <= next_state == cbrf_pkg::CBRF_ST_EXCH;
            imm_fault <= issue && imm_bad;
            src_bus <= src_val;
            mem_we <= do_mem_wr;
            mem_re <= do_mem_rd;
            if (do_mem_wr || do_mem_rd)
                mem_addr <= addr_val;
            if (do_mem_wr)
                mem_wdata <= dst_bus;
            tx_push <= issue && !mem_wr && dst_fifo;
            if (issue && dst_fifo)
                tx_fifo_data <= dst_bus;
            rx_pop <= issue && src_fifo
                && instr_src == cbrf_pkg::CBRF_SRC_REG;
            alt_a_sel <= state == cbrf_pkg::CBRF_ST_EXCH ? pend_a : bank_a;
            alt_b_sel <= state == cbrf_pkg::CBRF_ST_EXCH ? pend_b : bank_b;
        end
    end

    // Host-side control register deliberately has no location here

    bank_reset_a: assert property (@(posedge core_clk)
        $fell(srst) |-> alt_a_sel && alt_b_sel)
        else $error("banks not alternate after reset");
    exch_two_a: assert property (@(posedge core_clk) disable iff (srst)
        exch_go |=> busy ##1 !busy)
        else $error("exchange not two states");
    exch_bank_a: assert property (@(posedge core_clk) disable iff (srst)
        exch_go |-> ##2 alt_a_sel == !$past(exch_main_a, 2))
        else $error("bank A not exchanged");
    imm_range_a: assert property (@(posedge core_clk) disable iff (srst)
        issue && is_imm && dst_loc[4] |=> imm_fault)
        else $error("immediate range not flagged");
    tx_push_a: assert property (@(posedge core_clk) disable iff (srst)
        issue && !mem_wr && dst_fifo |=> tx_push
        && tx_fifo_data == $past(dst_bus))
        else $error("fifo write not pushed");
    mem_write_a: assert property (@(posedge core_clk) disable iff (srst)
        do_mem_wr |=> mem_we && mem_wdata == $past(dst_bus)
        && mem_addr == $past(addr_val))
        else $error("memory write mismatch");
    same_reg_a: assert property (@(posedge core_clk) disable iff (srst)
        do_reg_wr && mif.rd_idx == mif.wr_idx && !is_idx_src && !src_fifo
        |=> src_bus == $past(mif.rd_data))
        else $error("source not old value");
    reg_store_a: assert property (@(posedge core_clk) disable iff (srst)
        do_reg_wr && !exch ##1 src_loc == $past(dst_loc)
        && !is_idx_src && !src_fifo && alt_b_sel == $past(alt_b_sel)
        && alt_a_sel == $past(alt_a_sel) |-> src_val == $past(dst_bus))
        else $error("register not stored");
    rx_pop_a: assert property (@(posedge core_clk) disable iff (srst)
        issue && src_fifo && instr_src == cbrf_pkg::CBRF_SRC_REG
        |=> rx_pop)
        else $error("fifo read not popped");
    cov_exch: cover property (@(posedge core_clk) exch_go);
    cov_mwr: cover property (@(posedge core_clk) mem_we);
    cov_push: cover property (@(posedge core_clk) tx_push);
    cov_pop: cover property (@(posedge core_clk) rx_pop);
endmodule
`default_nettype wire
